// [rtl/spmc_map.svh]
`ifndef SPMC_MAP_SVH
`define SPMC_MAP_SVH
// Summary of operation
// - master drives mosi, slave drives miso
// - both data lines shift msb first
// - master mosi carries shift register msb
// - miso floats when disabled or deselected
// - three-wire slave always drives miso msb
// - sck driven only as master
// - deselected four-wire slave ignores sck
// - mode 00 three-wire, slave always selected
// - mode 01 select input, low selects
// - select falling edge disables master in 01
// - mode 1x drives select pin lower bit
// - select pin mapped except in mode 00
// - data write fills buffer, starts transfer
// - mode fault clears enables, sets fault flag
// - eight slave bits set done, fill receive unless still full (overrun flag then)
// - select falling edge resets four-wire slave bit counter

// ----------------------------------------
// register offsets
// ----------------------------------------
`define SPMC_OFF_CTRL   4'h0
`define SPMC_OFF_DATA   4'h4
`define SPMC_OFF_STS    4'h8
`define SPMC_OFF_MASK   4'hC

// ----------------------------------------
// control fields and reset values
// ----------------------------------------
`define SPMC_CTRL_PORT  0
`define SPMC_CTRL_MSTR  1
`define SPMC_CTRL_MODE  2
`define SPMC_MODE_3W    2'h0
`define SPMC_MODE_MM    2'h1
`define SPMC_RST_MODE   2'h1

// ----------------------------------------
// status bits
// ----------------------------------------
`define SPMC_ST_DONE    0
`define SPMC_ST_WCOL    1
`define SPMC_ST_MODE_FAULT_FLAG    2
`define SPMC_ST_OVR     3

// ----------------------------------------
// bus answers and timing
// ----------------------------------------
`define SPMC_RESP_OKAY  2'h0
`define SPMC_RESP_SLV   2'h2
`define SPMC_SCK_HALF   8'h0A
`define SPMC_LAST_BIT   3'h7
`endif

// [rtl/spmc_pkg.sv]
package spmc_pkg;
	// master clock engine phases
	typedef enum logic [2:0] {
		SPMC_IDLE = 3'b001,
		SPMC_LOW  = 3'b010,
		SPMC_HIGH = 3'b100
	} spmc_mst_t;

	// whole state of the port
	typedef struct packed {
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
		logic        port_en;
		logic        mstr_en;
		logic [1:0]  sel_mode;
		logic [3:0]  sts;
		logic [3:0]  msk;
		logic        irq;
		logic [7:0]  txbuf;
		logic        txfull;
		logic [7:0]  shreg;
		logic        shfull;
		logic [7:0]  rxbuf;
		logic        rxfull;
		logic [2:0]  bitcnt;
		logic [7:0]  div;
		spmc_mst_t   mst;
		logic        sck_out;
		logic        rbit;
		logic        sck_q;
		logic        nss_q;
	} spmc_state_t;
endpackage

// [rtl/spmc_sync.sv]
`timescale 1ns/10ps
module spmc_sync #(
	parameter int W = 4
) (
	input  wire logic         clock, // system clock
	input  wire logic         rst_n, // async reset, low
	input  wire logic [W-1:0] din,   // raw pin levels
	output logic      [W-1:0] dout   // synchronised levels
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stab;
	} spmc_sync_t;

	spmc_sync_t sync_reg;
	spmc_sync_t sync_next;

	// two stage chain, first stage feeds only the second
	always_comb begin
		sync_next      = sync_reg;
		sync_next.meta = din;
		sync_next.stab = sync_reg.meta;
	end

	// state register
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sync_reg <= '0;
		end else begin
			sync_reg <= sync_next;
		end
	end

	assign dout = sync_reg.stab;
endmodule

// [rtl/spmc_top.sv]
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
`include "spmc_map.svh"
module spmc_top import spmc_pkg::*; #(
	parameter logic [7:0] HALF = `SPMC_SCK_HALF
) (
	input  wire logic        clock,         // system clock
	input  wire logic        rst_n,         // async reset, low
	input  wire logic [3:0]  s_axi_awaddr,  // write address
	input  wire logic [2:0]  s_axi_awprot,  // unused
	input  wire logic        s_axi_awvalid, // write address valid
	output logic             s_axi_awready, // write address ready
	input  wire logic [31:0] s_axi_wdata,   // write data
	input  wire logic [3:0]  s_axi_wstrb,   // byte enables
	input  wire logic        s_axi_wvalid,  // write data valid
	output logic             s_axi_wready,  // write data ready
	output logic [1:0]       s_axi_bresp,   // write answer
	output logic             s_axi_bvalid,  // write answer valid
	input  wire logic        s_axi_bready,  // write answer ready
	input  wire logic [3:0]  s_axi_araddr,  // read address
	input  wire logic [2:0]  s_axi_arprot,  // unused
	input  wire logic        s_axi_arvalid, // read address valid
	output logic             s_axi_arready, // read address ready
	output logic [31:0]      s_axi_rdata,   // read data
	output logic [1:0]       s_axi_rresp,   // read answer
	output logic             s_axi_rvalid,  // read answer valid
	input  wire logic        s_axi_rready,  // read answer ready
	input  wire logic        sck_i,         // serial clock in
	output logic             sck_o,         // serial clock out
	output logic             sck_oe,        // serial clock drive
	input  wire logic        mosi_i,        // master data in
	output logic             mosi_o,        // master data out
	output logic             mosi_oe,       // master data drive
	input  wire logic        miso_i,        // slave data in
	output logic             miso_o,        // slave data out
	output logic             miso_oe,       // slave data drive
	input  wire logic        nss_i,         // select in
	output logic             nss_o,         // select out
	output logic             nss_oe,        // select drive
	output logic             nss_map,       // select routed to pin
	output logic             irq            // interrupt level
);
	// ----------------------------------------
	// declarations
	// ----------------------------------------
	spmc_state_t state_reg;
	spmc_state_t state_next;
	logic [3:0]  pin_s;
	logic        sck_s;
	logic        nss_s;
	logic        mosi_s;
	logic        miso_s;
	logic        wr_go;
	logic        rd_go;
	logic        selected;
	logic        slave_act;
	logic        four_slave;
	logic        sck_rise;
	logic        sck_fall;
	logic        nss_fall;
	logic        byte_done;
	logic        sh_free;
	logic [7:0]  shin;
	logic [3:0]  ev;
	logic [3:0]  clr;

	// pin synchronisers
	spmc_sync #(.W(4)) u_sync (
		.clock (clock),
		.rst_n (rst_n),
		.din   ({sck_i, nss_i, mosi_i, miso_i}),
		.dout  (pin_s)
	);
	assign sck_s  = pin_s[3];
	assign nss_s  = pin_s[2];
	assign mosi_s = pin_s[1];
	assign miso_s = pin_s[0];

	// ----------------------------------------
	// decode of pin events and roles
	// ----------------------------------------
	assign selected   = (state_reg.sel_mode == `SPMC_MODE_3W) |
		((state_reg.sel_mode == `SPMC_MODE_MM) & ~nss_s);
	assign slave_act  = state_reg.port_en & ~state_reg.mstr_en & selected;
	assign four_slave = state_reg.port_en & ~state_reg.mstr_en &
		(state_reg.sel_mode == `SPMC_MODE_MM);
	assign sck_rise   = sck_s & ~state_reg.sck_q;
	assign sck_fall   = ~sck_s & state_reg.sck_q;
	assign nss_fall   = state_reg.nss_q & ~nss_s;
	assign shin       = {state_reg.shreg[6:0], state_reg.rbit};

	// bus handshakes
	assign wr_go = s_axi_awvalid & s_axi_wvalid & ~state_reg.bvalid;
	assign rd_go = s_axi_arvalid & ~state_reg.rvalid;
	assign s_axi_awready = wr_go;
	assign s_axi_wready  = wr_go;
	assign s_axi_arready = ~state_reg.rvalid;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		state_next       = state_reg;
		byte_done        = 1'b0;
		ev               = 4'h0;
		clr              = 4'h0;
		sh_free          = 1'b0;
		state_next.sck_q = sck_s;
		state_next.nss_q = nss_s;
		if (state_reg.bvalid & s_axi_bready) begin
			state_next.bvalid = 1'b0;
		end
		if (state_reg.rvalid & s_axi_rready) begin
			state_next.rvalid = 1'b0;
		end

		// master clock engine, mode 0 timing
		unique case (state_reg.mst)
			SPMC_IDLE: begin
				if (state_reg.port_en & state_reg.mstr_en &
					state_reg.shfull) begin
					state_next.mst = SPMC_LOW;
					state_next.div = 8'h00;
				end
			end
			SPMC_LOW: begin
				state_next.div = state_reg.div + 8'h01;
				if (state_reg.div == HALF - 8'h01) begin
					state_next.sck_out = 1'b1;
					state_next.rbit    = miso_s;
					state_next.div     = 8'h00;
					state_next.mst     = SPMC_HIGH;
				end
			end
			SPMC_HIGH: begin
				state_next.div = state_reg.div + 8'h01;
				if (state_reg.div == HALF - 8'h01) begin
					state_next.sck_out = 1'b0;
					state_next.div     = 8'h00;
					state_next.shreg   = shin;
					state_next.bitcnt  = state_reg.bitcnt + 3'h1;
					if (state_reg.bitcnt == `SPMC_LAST_BIT) begin
						byte_done      = 1'b1;
						state_next.mst = SPMC_IDLE;
					end else begin
						state_next.mst = SPMC_LOW;
					end
				end
			end
		endcase

		// slave engine, sck ignored while not selected
		if (slave_act) begin
			if (sck_rise) begin
				state_next.rbit = mosi_s;
			end
			if (sck_fall) begin
				state_next.shreg  = shin;
				state_next.bitcnt = state_reg.bitcnt + 3'h1;
				if (state_reg.bitcnt == `SPMC_LAST_BIT) begin
					byte_done = 1'b1;
				end
			end
		end
		if (four_slave & nss_fall) begin
			state_next.bitcnt = 3'h0;
		end

		// a disabled port holds its engines at rest
		if (~state_reg.port_en) begin
			state_next.mst     = SPMC_IDLE;
			state_next.sck_out = 1'b0;
			state_next.bitcnt  = 3'h0;
		end

		// register reads, data read frees the receive buffer
		if (rd_go) begin
			state_next.rvalid = 1'b1;
			state_next.rresp  = `SPMC_RESP_OKAY;
			state_next.rdata  = 32'h0;
			case (s_axi_araddr)
				`SPMC_OFF_CTRL: state_next.rdata[3:0] = {state_reg.sel_mode,
					state_reg.mstr_en, state_reg.port_en};
				`SPMC_OFF_DATA: begin
					state_next.rdata[7:0] = state_reg.rxbuf;
					state_next.rxfull     = 1'b0;
				end
				`SPMC_OFF_STS:  state_next.rdata[3:0] = state_reg.sts;
				`SPMC_OFF_MASK: state_next.rdata[3:0] = state_reg.msk;
				default:        state_next.rresp = `SPMC_RESP_SLV;
			endcase
		end

		// end of byte: receive, overrun, reload from buffer
		if (byte_done) begin
			state_next.shfull = 1'b0;
			ev[`SPMC_ST_DONE] = 1'b1;
			if (state_reg.rxfull & ~state_reg.mstr_en) begin
				ev[`SPMC_ST_OVR] = 1'b1;
			end else begin
				state_next.rxbuf  = shin;
				state_next.rxfull = 1'b1;
			end
			if (state_reg.txfull) begin
				state_next.shreg  = state_reg.txbuf;
				state_next.txfull = 1'b0;
				state_next.shfull = 1'b1;
			end
		end

		// multi-master fault on select falling edge
		if (state_reg.port_en & state_reg.mstr_en & nss_fall &
			(state_reg.sel_mode == `SPMC_MODE_MM)) begin
			state_next.mstr_en = 1'b0;
			state_next.port_en = 1'b0;
			state_next.mst     = SPMC_IDLE;
			state_next.sck_out = 1'b0;
			state_next.bitcnt  = 3'h0;
			state_next.shfull  = 1'b0;
			ev[`SPMC_ST_MODE_FAULT_FLAG]  = 1'b1;
		end

		// register writes
		sh_free = ~state_reg.shfull & (state_reg.bitcnt == 3'h0) &
			(state_reg.mst == SPMC_IDLE) & ~byte_done;
		if (wr_go) begin
			state_next.bvalid = 1'b1;
			state_next.bresp  = `SPMC_RESP_OKAY;
			case (s_axi_awaddr)
				`SPMC_OFF_CTRL: begin
					if (s_axi_wstrb[0]) begin
						state_next.port_en  = s_axi_wdata[`SPMC_CTRL_PORT];
						state_next.mstr_en  = s_axi_wdata[`SPMC_CTRL_MSTR];
						state_next.sel_mode = s_axi_wdata[3:2];
					end
				end
				`SPMC_OFF_DATA: begin
					if (s_axi_wstrb[0]) begin
						if (state_reg.txfull) begin
							ev[`SPMC_ST_WCOL] = 1'b1;
						end else if (sh_free) begin
							state_next.shreg  = s_axi_wdata[7:0];
							state_next.shfull = 1'b1;
						end else begin
							state_next.txbuf  = s_axi_wdata[7:0];
							state_next.txfull = 1'b1;
						end
					end
				end
				`SPMC_OFF_STS: begin
					if (s_axi_wstrb[0]) begin
						clr = s_axi_wdata[3:0];
					end
				end
				`SPMC_OFF_MASK: begin
					if (s_axi_wstrb[0]) begin
						state_next.msk = s_axi_wdata[3:0];
					end
				end
				default: state_next.bresp = `SPMC_RESP_SLV;
			endcase
		end

		// sticky flags, a new event beats a clear
		state_next.sts = (state_reg.sts & ~clr) | ev;
		state_next.irq = |(state_next.sts & state_next.msk);
	end

	// state register
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_reg          <= '0;
			state_reg.mst      <= SPMC_IDLE;
			state_reg.sel_mode <= `SPMC_RST_MODE;
			state_reg.sck_q    <= 1'b0;
			state_reg.nss_q    <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign s_axi_bvalid = state_reg.bvalid;
	assign s_axi_bresp  = state_reg.bresp;
	assign s_axi_rvalid = state_reg.rvalid;
	assign s_axi_rresp  = state_reg.rresp;
	assign s_axi_rdata  = state_reg.rdata;
	assign irq          = state_reg.irq;
	// pin directions by role and select mode
	assign sck_o   = state_reg.sck_out;
	assign sck_oe  = state_reg.port_en & state_reg.mstr_en;
	assign mosi_o  = state_reg.shreg[7];
	assign mosi_oe = state_reg.port_en & state_reg.mstr_en;
	assign miso_o  = state_reg.shreg[7];
	assign miso_oe = slave_act;
	assign nss_o   = state_reg.sel_mode[0];
	assign nss_oe  = state_reg.sel_mode[1];
	assign nss_map = (state_reg.sel_mode != `SPMC_MODE_3W);

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_master_dirs: assert property (state_reg.port_en & state_reg.mstr_en
		|-> mosi_oe && sck_oe && !miso_oe)
		else $error("master pin directions wrong");
	a_msb_shift: assert property ($fell(sck_o) && mosi_oe
		&& state_reg.bitcnt != 3'h0
		|-> mosi_o == $past(state_reg.shreg[6]))
		else $error("mosi not next msb after shift");
	a_miso_hiz: assert property (!state_reg.port_en || (four_slave
		&& nss_s) |-> !miso_oe)
		else $error("miso driven while off or deselected");
	a_miso_3wire: assert property (state_reg.port_en
		&& !state_reg.mstr_en && state_reg.sel_mode == 2'h0
		|-> miso_oe && miso_o == state_reg.shreg[7])
		else $error("three wire slave not driving miso");
	a_sck_owner: assert property (sck_oe |-> state_reg.mstr_en)
		else $error("sck driven as slave");
	a_sck_ignored: assert property (four_slave && nss_s && !nss_fall
		|=> state_reg.bitcnt == $past(state_reg.bitcnt))
		else $error("deselected slave counted sck");
	a_fault_off: assert property (state_reg.port_en && state_reg.mstr_en
		&& state_reg.sel_mode == 2'h1 && nss_fall
		|=> !state_reg.mstr_en && !state_reg.port_en
		&& state_reg.sts[2])
		else $error("mode fault not taken");
	a_nss_drive: assert property (state_reg.sel_mode[1]
		|-> nss_oe && nss_o == state_reg.sel_mode[0] && nss_map)
		else $error("select output wrong");
	a_nss_unmap: assert property (state_reg.sel_mode == 2'h0
		|-> !nss_map && !nss_oe)
		else $error("select mapped in three wire mode");
	a_tx_start: assert property (wr_go && s_axi_awaddr == 4'h4
		&& s_axi_wstrb[0] && !state_reg.txfull && sh_free
		&& state_reg.port_en && state_reg.mstr_en
		|=> state_reg.shfull ##1 state_reg.mst == SPMC_LOW)
		else $error("transfer did not start");
	a_done_flag: assert property (byte_done |=> state_reg.sts[0])
		else $error("done flag not set");
	a_cnt_clear: assert property (four_slave && nss_fall
		|=> state_reg.bitcnt == 3'h0)
		else $error("bit counter not cleared");

	c_master_byte: cover property (byte_done && state_reg.mstr_en);
	c_slave_byte:  cover property (byte_done && !state_reg.mstr_en);
	c_mode_fault:  cover property (ev[2]);
	c_collision:   cover property (ev[1]);
endmodule

// [sim/spmc_peer.sv]
`timescale 1ns/10ps
// ----------------------------------------
// far side: sole slave always, master on call
// ----------------------------------------
module spmc_peer (
	input  wire logic       sck_w,  // sck line level
	input  wire logic       mosi_w, // mosi line level
	input  wire logic       miso_w, // miso line level
	output logic            sck_m,  // sck while peer masters
	output logic            mosi_m, // mosi while peer masters
	output logic            miso_s, // miso as the only slave
	output logic [7:0]      got     // last bits seen on mosi
);
	logic [7:0] sh = 8'h00; // slave shift register

	initial begin
		sck_m = 1'b0;
		mosi_m = 1'b0;
		miso_s = 1'b0;
		got = 8'h00;
	end

	// preload the reply byte, msb on the line at once
	task automatic load(input logic [7:0] b);
		sh = b;
		miso_s = b[7];
	endtask

	// slave side: sample at rise, shift at fall, never addressed
	always @(posedge sck_w) got = {got[6:0], mosi_w};
	always @(negedge sck_w) begin
		sh = {sh[6:0], ~sh[0]};
		miso_s = sh[7];
	end

	// master side: n bits, 160 ns period, clock idle low
	task automatic xfer(input logic [7:0] b, input int n,
		output logic [7:0] r);
		r = 8'h00;
		for (int i = 7; i > 7 - n; i--) begin
			mosi_m = b[i];
			#80 sck_m = 1'b1;
			r = {r[6:0], miso_w};
			#80 sck_m = 1'b0;
		end
		mosi_m = ~mosi_m; // no stale bit after the frame
	endtask
endmodule

// [sim/test_spi_pin_mode_control.sv]
`timescale 1ns/10ps
`include "spmc_map.svh"
module test_spi_pin_mode_control;
	logic        clock = 1'b0;
	logic        rst_n = 1'b0;
	logic [3:0]  awaddr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic [3:0]  araddr = 4'h0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic        nss_drv = 1'b1;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, rr_q;
	logic [31:0] rdata, rd_q;
	logic        sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
	logic        nss_o, nss_oe, nss_map, irq;
	logic        sck_m, mosi_m, miso_s;
	logic        sck_i, mosi_i, miso_i, nss_i;
	logic [7:0]  got, b, p, q, r;
	int          failures = 0;
	int          n_tests = 0;
	int          seed = 32'h63634528;

	always #4 clock = ~clock;

	// line levels from whoever drives each pin
	assign sck_i = sck_oe ? sck_o : sck_m;
	assign mosi_i = mosi_oe ? mosi_o : mosi_m;
	assign miso_i = miso_oe ? miso_o : miso_s;
	assign nss_i = nss_oe ? nss_o : nss_drv;

	spmc_top #(.HALF(8'h03)) dut (
		.clock(clock), .rst_n(rst_n), .s_axi_awaddr(awaddr),
		.s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .sck_i(sck_i), .sck_o(sck_o),
		.sck_oe(sck_oe), .mosi_i(mosi_i), .mosi_o(mosi_o),
		.mosi_oe(mosi_oe), .miso_i(miso_i), .miso_o(miso_o),
		.miso_oe(miso_oe), .nss_i(nss_i), .nss_o(nss_o), .nss_oe(nss_oe),
		.nss_map(nss_map), .irq(irq)
	);

	spmc_peer peer (
		.sck_w(sck_i), .mosi_w(mosi_i), .miso_w(miso_i), .sck_m(sck_m),
		.mosi_m(mosi_m), .miso_s(miso_s), .got(got)
	);

	// ----------------------------------------
	// comparisons and closing
	// ----------------------------------------
	task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic chk_pin(input logic g, input logic e);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// expected control word from its fields
	function automatic logic [31:0] exp_ctrl(input logic [1:0] md,
		input logic ms, input logic en);
		return {28'h0, md, ms, en};
	endfunction

	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// ----------------------------------------
	// bus master cycles
	// ----------------------------------------
	task automatic axw(input logic [3:0] a, input logic [31:0] d,
		input logic [1:0] er);
		int k;
		k = 0;
		@(posedge clock);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clock);
			k++;
		end while (!(awready && wready) && k < 200);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do begin
			@(posedge clock);
			k++;
		end while (!bvalid && k < 200);
		bready <= 1'b0;
		chk_pin(bvalid, 1'b1);
		chk_word({30'h0, bresp}, {30'h0, er});
	endtask

	task automatic axr(input logic [3:0] a);
		int k;
		k = 0;
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clock);
			k++;
		end while (!arready && k < 200);
		arvalid <= 1'b0;
		do begin
			@(posedge clock);
			k++;
		end while (!rvalid && k < 200);
		rready <= 1'b0;
		rd_q = rdata;
		rr_q = rresp;
		chk_pin(rvalid, 1'b1);
	endtask

	// poll status until the given bits show, bounded
	task automatic wait_flag(input logic [31:0] m);
		int k;
		k = 0;
		do begin
			axr(`SPMC_OFF_STS);
			k++;
		end while ((rd_q & m) == 32'h0 && k < 400);
		chk_word(rd_q & m, m);
	endtask

	// slave byte driven by the peer, then six clocks to settle
	task automatic slave_byte(input logic [7:0] tx, input int n);
		peer.xfer(tx, n, r);
		repeat (6) @(posedge clock);
	endtask

	// ----------------------------------------
	// watchdog and main sequence
	// ----------------------------------------
	initial begin
		#300000;
		failures++;
		complete_run;
	end

	initial begin
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		// reset state and an unmapped place
		axr(`SPMC_OFF_CTRL);
		chk_word(rd_q, exp_ctrl(`SPMC_RST_MODE, 1'b0, 1'b0));
		axr(4'h2);
		chk_word({30'h0, rr_q}, {30'h0, `SPMC_RESP_SLV});
		chk_word(rd_q, 32'h0);
		axw(4'h2, 32'h0, `SPMC_RESP_SLV);
		chk_pin(miso_oe, 1'b0);
		chk_pin(sck_oe, 1'b0);
		chk_pin(nss_map, 1'b1);
		$display("test reset done");
		// master in modes 00, 10, 11 with random bytes, irq unmasked
		axw(`SPMC_OFF_MASK, 32'h1, `SPMC_RESP_OKAY);
		for (int m = 0; m < 4; m++) begin
			if (m == 1) continue;
			b = 8'($random(seed));
			p = 8'($random(seed));
			peer.load(p);
			axw(`SPMC_OFF_CTRL, 32'h3 | 32'(m << 2), `SPMC_RESP_OKAY);
			@(negedge clock);
			chk_pin(mosi_oe, 1'b1);
			chk_pin(miso_oe, 1'b0);
			chk_pin(sck_oe, 1'b1);
			chk_pin(nss_map, m != 0);
			chk_pin(nss_oe, m[1]);
			if (m[1]) chk_pin(nss_o, m[0]);
			axw(`SPMC_OFF_DATA, {24'h0, b}, `SPMC_RESP_OKAY);
			wait_flag(32'h1);
			chk_pin(irq, 1'b1);
			chk_word({24'h0, got}, {24'h0, b});
			axr(`SPMC_OFF_DATA);
			chk_word(rd_q, {24'h0, p});
			axw(`SPMC_OFF_STS, 32'hF, `SPMC_RESP_OKAY);
			@(negedge clock);
			chk_pin(irq, 1'b0);
		end
		$display("test master done");
		// four-wire slave, irq masked, clocks while deselected
		axw(`SPMC_OFF_MASK, 32'h0, `SPMC_RESP_OKAY);
		axw(`SPMC_OFF_CTRL, 32'h5, `SPMC_RESP_OKAY);
		p = 8'($random(seed));
		axw(`SPMC_OFF_DATA, {24'h0, p}, `SPMC_RESP_OKAY);
		@(negedge clock);
		chk_pin(miso_oe, 1'b0);
		chk_pin(mosi_oe, 1'b0);
		chk_pin(sck_oe, 1'b0);
		slave_byte(8'hFF, 8);
		axr(`SPMC_OFF_STS);
		chk_word(rd_q, 32'h0);
		nss_drv <= 1'b0;
		repeat (4) @(negedge clock);
		chk_pin(miso_oe, 1'b1);
		b = 8'($random(seed));
		slave_byte(b, 8);
		chk_word({24'h0, r}, {24'h0, p});
		wait_flag(32'h1);
		chk_pin(irq, 1'b0);
		axr(`SPMC_OFF_DATA);
		chk_word(rd_q, {24'h0, b});
		axw(`SPMC_OFF_STS, 32'hF, `SPMC_RESP_OKAY);
		// broken frame, then reselect restarts the count
		slave_byte(8'h00, 3);
		nss_drv <= 1'b1;
		repeat (4) @(posedge clock);
		nss_drv <= 1'b0;
		repeat (4) @(posedge clock);
		b = 8'($random(seed));
		slave_byte(b, 8);
		wait_flag(32'h1);
		axr(`SPMC_OFF_DATA);
		chk_word(rd_q, {24'h0, b});
		axw(`SPMC_OFF_STS, 32'hF, `SPMC_RESP_OKAY);
		nss_drv <= 1'b1;
		$display("test slave4 done");
		// three-wire slave, always selected, second byte buffered
		axw(`SPMC_OFF_CTRL, 32'h1, `SPMC_RESP_OKAY);
		p = 8'($random(seed));
		q = 8'($random(seed));
		axw(`SPMC_OFF_DATA, {24'h0, p}, `SPMC_RESP_OKAY);
		@(negedge clock);
		chk_pin(miso_oe, 1'b1);
		chk_pin(nss_map, 1'b0);
		// a third write while the buffer is full collides
		axw(`SPMC_OFF_DATA, {24'h0, q}, `SPMC_RESP_OKAY);
		axw(`SPMC_OFF_DATA, 32'h0, `SPMC_RESP_OKAY);
		wait_flag(32'h2);
		b = 8'($random(seed));
		slave_byte(b, 8);
		chk_word({24'h0, r}, {24'h0, p});
		wait_flag(32'h1);
		// unread byte: next one overruns, buffered byte goes out
		slave_byte(8'($random(seed)), 8);
		chk_word({24'h0, r}, {24'h0, q});
		wait_flag(32'h8);
		axr(`SPMC_OFF_DATA);
		chk_word(rd_q, {24'h0, b});
		axw(`SPMC_OFF_STS, 32'hF, `SPMC_RESP_OKAY);
		$display("test slave3 done");
		// multi-master: select falls, master gives way
		axw(`SPMC_OFF_MASK, 32'h4, `SPMC_RESP_OKAY);
		axw(`SPMC_OFF_CTRL, 32'h7, `SPMC_RESP_OKAY);
		@(negedge clock);
		chk_pin(sck_oe, 1'b1);
		@(posedge clock);
		nss_drv <= 1'b0;
		repeat (6) @(posedge clock);
		chk_pin(sck_oe, 1'b0);
		axr(`SPMC_OFF_CTRL);
		chk_word(rd_q, exp_ctrl(`SPMC_MODE_MM, 1'b0, 1'b0));
		wait_flag(32'h4);
		chk_pin(irq, 1'b1);
		$display("test fault done");
		complete_run;
	end
endmodule
